// ===== bench/nfsd_tb.sv
// Self-checking bench for the field-select decode core.
// Assumes the core's APB slave answers with zero wait states; pready is still polled.
`timescale 1ns/100ps
`define CHK(nm, ex, gt) begin cmp_count++; if ((ex) !== (gt)) begin num_errors++; \
	$display("CHECK FAILED %s expected %h seen %h", nm, ex, gt); end end
module testbench;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        carry_flag;
	logic        int_enable;
	logic [19:0] prog_counter;
	int          num_errors = 0;
	int          cmp_count = 0;
	integer      seed = 84784;
	logic [31:0] rd;
	logic        er;
	logic [63:0] rg [4];
	logic [19:0] stk [$];
	logic [19:0] epc, tgt;
	logic        ec, eie, t;
	logic [3:0]  p, n, fs;
	logic [15:0] pst;
	logic [3:0]  hst;
	logic [2:0]  c, pr;
	logic [4:0]  dc;
	logic        af, ex, yr;
	logic [3:0]  op;
	logic [1:0]  jl;
	int          ri [5] = '{0, 1, 2, 2, 3};
	int          si [5] = '{1, 2, 0, 3, 2};

	nfsd_core i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.carry_flag(carry_flag), .int_enable(int_enable), .prog_counter(prog_counter));

	// Free-running 250 MHz clock
	always #2 pclk = ~pclk;

	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// One APB transfer; request held until pready is seen at a rising edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (k = 0; k < 50; k++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		if (k == 50) begin
			num_errors++;
			end_sim();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		`CHK(nm, e, rd)
	endtask

	// Digits are supplied in printed order; the first one is least significant
	function automatic logic [19:0] rev(input logic [19:0] v, input int k);
		rev = '0;
		for (int i = 0; i < k; i++) rev[4*i+:4] = v[4*(k-1-i)+:4];
	endfunction

	function automatic logic [19:0] dest(input logic [1:0] j, input logic [19:0] v, input logic [19:0] pc);
		logic [19:0] r;
		r = rev(v, j == 2'd0 ? 2 : (j == 2'd1 ? 4 : 5));
		if (j == 2'd0) dest = pc + 20'h0_0001 + {{12{r[7]}}, r[7:0]};
		else if (j == 2'd1) dest = pc + 20'h0_0001 + {{4{r[15]}}, r[15:0]};
		else dest = r;
	endfunction

	// Register digit mask of a field selection
	function automatic logic [63:0] fmask(input logic [3:0] f, input logic a, input logic x,
		input logic [4:0] d, input logic [3:0] pp);
		logic [16:0] m;
		if (a) m = 17'h0_001F;
		else if (x) m = (17'h0_0001 << d) - 17'h0_0001;
		else case (f[2:0])
			3'd0: m = 17'h0_0001 << pp;
			3'd1: m = (17'h0_0002 << pp) - 17'h0_0001;
			3'd2: m = 17'h0_0004;
			3'd3: m = 17'h0_0007;
			3'd4: m = 17'h0_8000;
			3'd5: m = 17'h0_7FF8;
			3'd6: m = 17'h0_0003;
			default: m = 17'h0_FFFF;
		endcase
		for (int i = 0; i < 16; i++) fmask[4*i+:4] = {4{m[i]}};
	endfunction

	function automatic logic rtest(input logic [2:0] cc, input logic [63:0] r, input logic [63:0] s);
		case (cc)
			3'd0: rtest = r == s;
			3'd1: rtest = r != s;
			3'd2: rtest = r == 0;
			3'd3: rtest = r != 0;
			3'd4: rtest = r > s;
			3'd5: rtest = r < s;
			3'd6: rtest = r >= s;
			default: rtest = r <= s;
		endcase
	endfunction

	function automatic logic [19:0] pop();
		pop = stk.size() == 0 ? 20'h0_0000 : stk.pop_back();
	endfunction

	// Execute one instruction and compare flow and carry against the model
	task automatic exec(input logic [31:0] ins);
		apb(1'b1, nfsd_pkg::OFF_TGT, {12'h000, tgt});
		apb(1'b1, nfsd_pkg::OFF_INSTR, ins);
		#1;
		`CHK("pc", epc, prog_counter)
		`CHK("carry", ec, carry_flag)
		`CHK("inten", eie, int_enable)
	endtask

	// Branch taken on a true test, or a return when yr is set, else fall through
	task automatic flow(input logic tr);
		ec = tr;
		if (!tr) epc = epc + 20'h0_0001;
		else if (yr) epc = pop();
		else epc = dest(2'd0, tgt, epc);
	endtask

	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		#1;
		`CHK("rst carry", 1'b0, carry_flag)
		`CHK("rst inten", 1'b1, int_enable)
		`CHK("rst pc", 20'h0_0000, prog_counter)
		rdchk("flags", nfsd_pkg::OFF_FLAGS, 32'h0000_0002);
		rdchk("unmapped", 8'h08, 32'h0000_0000);
		`CHK("slverr", 1'b1, er)
		epc = '0; ec = 0; eie = 1; yr = 0;
		$display("reset test done");
		// Register tests across every field code, address field and digit counts
		for (int k = 0; k < 128; k++) begin
			pr = 3'($unsigned($random(seed)) % 5);
			for (int i = 0; i < 4; i++) rg[i] = {$random(seed), $random(seed)};
			if (k % 3 == 0) rg[si[pr]] = rg[ri[pr]] ^ (64'h1 << k[5:0]);
			if (k % 5 == 1) rg[ri[pr]] = '0;
			for (int i = 0; i < 4; i++) begin
				apb(1'b1, nfsd_pkg::OFF_WREG + 8'(8*i), rg[i][31:0]);
				apb(1'b1, nfsd_pkg::OFF_WREG + 8'(8*i+4), rg[i][63:32]);
			end
			p = 4'($random(seed));
			apb(1'b1, nfsd_pkg::OFF_PTR, {28'h0, p});
			fs = 4'(k / 4); af = k % 4 == 2; ex = k % 4 == 3;
			dc = 5'($unsigned($random(seed)) % 17);
			c = 3'($random(seed)); tgt = 20'($random(seed));
			t = rtest(c, rg[ri[pr]] & fmask(fs, af, ex, dc, p), rg[si[pr]] & fmask(fs, af, ex, dc, p));
			flow(t);
			exec({4'h0, 2'd0, 1'b0, 4'h0, pr, c, dc, ex, af, fs, 4'hC});
		end
		$display("register test done");
		// Pointer, hardware and program status tests, each after a call, then branching, returning or falling through
		for (int k = 0; k < 90; k++) begin
			tgt = 20'($random(seed));
			stk.push_back(epc + 20'h0_0001);
			if (stk.size() > 8) void'(stk.pop_front());
			epc = rev(tgt, 5);
			exec(32'h0800_0004);
			p = 4'($random(seed)); hst = 4'($random(seed)); pst = 16'($random(seed));
			n = k % 2 ? p : 4'($random(seed));
			c = 3'($random(seed)); yr = k[2]; tgt = 20'($random(seed));
			apb(1'b1, nfsd_pkg::OFF_PTR, {28'h0, p});
			apb(1'b1, nfsd_pkg::OFF_HST, {28'h0, hst});
			apb(1'b1, nfsd_pkg::OFF_PST, {16'h0, pst});
			op = 4'hD + 4'(k % 3);
			if (op == 4'hD) t = c[0] ? p != n : p == n;
			else if (op == 4'hE) t = !hst[n[1:0]];
			else t = (c[1:0] == 0 || c[1:0] == 3) ? pst[n] : !pst[n];
			flow(t);
			exec({4'h0, 2'd0, yr, n, 3'd0, c, 5'd0, 2'b00, 4'h0, op});
			rdchk("hst kept", nfsd_pkg::OFF_HST, {28'h0, hst});
		end
		$display("status test done");
		// Jumps, calls and every return kind, with all jump lengths
		yr = 0;
		for (int k = 0; k < 96; k++) begin
			op = 4'(k % 12); jl = 2'(k / 24);
			ec = k[4]; eie = k[3]; tgt = 20'($random(seed));
			apb(1'b1, nfsd_pkg::OFF_FLAGS, {30'h0, eie, ec});
			apb(1'b1, nfsd_pkg::OFF_HST, 32'h0000_0000);
			case (op)
				4'h0: epc = epc + 20'h0_0001;
				4'h1: epc = dest(jl, tgt, epc);
				4'h2: epc = ec ? dest(jl, tgt, epc) : epc + 20'h0_0001;
				4'h3: epc = !ec ? dest(jl, tgt, epc) : epc + 20'h0_0001;
				4'h4: begin
					stk.push_back(epc + 20'h0_0001);
					if (stk.size() > 8) void'(stk.pop_front());
					epc = dest(jl, tgt, epc);
				end
				4'h6: begin epc = pop(); ec = 1; end
				4'h7: begin epc = pop(); ec = 0; end
				4'h9: begin epc = pop(); eie = 1; end
				4'hA: epc = ec ? pop() : epc + 20'h0_0001;
				4'hB: epc = !ec ? pop() : epc + 20'h0_0001;
				default: epc = pop();
			endcase
			exec({4'h0, jl, 22'h0, op});
			rdchk("hst", nfsd_pkg::OFF_HST, {31'h0, op == 4'h8});
			rdchk("flags", nfsd_pkg::OFF_FLAGS, {24'h0, 4'(stk.size()), 2'b00, eie, ec});
		end
		$display("flow test done");
		end_sim();
	end
endmodule

// ===== include/nfsd_pkg.sv
// Constants and types for the nibble field-select decode core.
// Assumes an APB master with 32-bit data and byte addresses.
package nfsd_pkg;
	// Register byte offsets
	localparam logic [7:0] OFF_INSTR = 8'h00;
	localparam logic [7:0] OFF_TGT   = 8'h04;
	localparam logic [7:0] OFF_WREG  = 8'h10;
	localparam logic [7:0] OFF_WEND  = 8'h2C;
	localparam logic [7:0] OFF_PTR   = 8'h30;
	localparam logic [7:0] OFF_PST   = 8'h34;
	localparam logic [7:0] OFF_HST   = 8'h38;
	localparam logic [7:0] OFF_FLAGS = 8'h3C;
	localparam logic [7:0] OFF_PC    = 8'h40;
	// Instruction word field positions
	localparam int OP_LSB   = 0;
	localparam int FS_LSB   = 4;
	localparam int AFLD_BIT = 8;
	localparam int EXT_BIT  = 9;
	localparam int DCNT_LSB = 10;
	localparam int COND_LSB = 15;
	localparam int PAIR_LSB = 18;
	localparam int IMM_LSB  = 21;
	localparam int YRTN_BIT = 25;
	localparam int JLEN_LSB = 26;
	// Flags register bits
	localparam int FL_CARRY = 0;
	localparam int FL_INTEN = 1;
	localparam int FL_DEPTH = 4;
	// Hardware status bit positions
	localparam int HST_MOD_MISSING = 0;
	localparam int HST_STICKY      = 1;
	localparam int HST_SVC_REQ     = 2;
	localparam int HST_MOD_PULLED  = 3;
	// Field codes, low three bits of the a or b nibble
	localparam logic [2:0] FS_PTR = 3'h0;
	localparam logic [2:0] FS_WP  = 3'h1;
	localparam logic [2:0] FS_ESGN = 3'h2;
	localparam logic [2:0] FS_X   = 3'h3;
	localparam logic [2:0] FS_S   = 3'h4;
	localparam logic [2:0] FS_M   = 3'h5;
	localparam logic [2:0] FS_B   = 3'h6;
	localparam logic [2:0] FS_W   = 3'h7;
	// Digit masks of the fixed fields
	localparam logic [16:0] MSK_ESGN = 17'h0_0004;
	localparam logic [16:0] MSK_X  = 17'h0_0007;
	localparam logic [16:0] MSK_S  = 17'h0_8000;
	localparam logic [16:0] MSK_M  = 17'h0_7FF8;
	localparam logic [16:0] MSK_B  = 17'h0_0003;
	localparam logic [16:0] MSK_W  = 17'h0_FFFF;
	localparam logic [16:0] MSK_A  = 17'h0_001F;
	// Reset values and stack depth
	localparam logic [19:0] RST_PC    = 20'h0_0000;
	localparam logic        RST_INTEN = 1'b1;
	localparam int          STK_DEPTH = 8;
	typedef enum logic [3:0] {
		OP_NOP, OP_JUMP, OP_BR_CARRY, OP_BR_NO_CARRY,
		OP_CALL, OP_RETURN, OP_RET_SET_CARRY, OP_RET_CLR_CARRY,
		OP_RET_MOD_MISSING, OP_RET_INTR, OP_RET_IF_CARRY, OP_RET_IF_NO_CARRY,
		OP_TEST_REG, OP_TEST_PTR, OP_TEST_HW, OP_TEST_PST
	} nfsd_op_t;
	typedef enum logic [2:0] {
		TC_EQ, TC_NE, TC_ZERO, TC_NZ, TC_GT, TC_LT, TC_GE, TC_LE
	} nfsd_cond_t;
	typedef struct packed {
		logic [3:0][63:0]  wreg;
		logic [3:0]        ptr;
		logic [15:0]       pst;
		logic [3:0]        hst;
		logic              carry;
		logic              inten;
		logic [19:0]       pc;
		logic [19:0]       tgt;
		logic [31:0]       instr;
		logic [7:0][19:0]  stk;
		logic [2:0]        sp;
		logic [3:0]        depth;
		logic [31:0]       rdata;
	} nfsd_state_t;
endpackage

// ===== rtl/nfsd_core.sv
// Field-select decode and branch/return/test execution core.
// Assumes an APB master; an instruction executes when its word is written.
`timescale 1ns/100ps

module nfsd_core (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             carry_flag,
	output logic             int_enable,
	output logic      [19:0] prog_counter
);

	nfsd_pkg::nfsd_state_t s_q;
	nfsd_pkg::nfsd_state_t s_d;

	// Decode helpers, all but mapped also watched by the checks below
	logic                 exec;
	logic                 mapped;
	nfsd_pkg::nfsd_op_t   op;
	logic                 is_test;
	logic                 tres;
	logic                 yrtn;
	logic [15:0]          dmask;
	logic [19:0]          nxt_pc;
	logic [19:0]          tgt_v;
	logic [19:0]          top;

	// Digit mask of the selected field
	function automatic logic [15:0] fs_mask(
		input logic [3:0] fs,
		input logic       afld,
		input logic       ext,
		input logic [4:0] dcnt,
		input logic [3:0] p
	);
		logic [16:0] t;
		t = 17'h0_0000;
		if (ext) begin
			t = (17'h0_0001 << dcnt) - 17'h0_0001;
		end else if (afld) begin
			t = nfsd_pkg::MSK_A;
		end else begin
			case (fs[2:0])
				nfsd_pkg::FS_PTR: t = 17'h0_0001 << p;
				nfsd_pkg::FS_WP:  t = (17'h0_0001 << ({1'b0, p} + 5'h01)) - 17'h0_0001;
				nfsd_pkg::FS_ESGN: t = nfsd_pkg::MSK_ESGN;
				nfsd_pkg::FS_X:   t = nfsd_pkg::MSK_X;
				nfsd_pkg::FS_S:   t = nfsd_pkg::MSK_S;
				nfsd_pkg::FS_M:   t = nfsd_pkg::MSK_M;
				nfsd_pkg::FS_B:   t = nfsd_pkg::MSK_B;
				default:          t = nfsd_pkg::MSK_W;
			endcase
		end
		return t[15:0];
	endfunction

	// Undo the reversed digit order of a k-digit immediate
	function automatic logic [19:0] nib_rev(
		input logic [19:0] v,
		input int          k
	);
		logic [19:0] r;
		r = 20'h0_0000;
		for (int i = 0; i < 5; i++) begin
			if (i < k) begin
				r[i*4 +: 4] = v[(k-1-i)*4 +: 4];
			end
		end
		return r;
	endfunction

	// Next state: bus access, then one instruction per write to INSTR
	always_comb begin
		logic [63:0]        m64;
		logic [63:0]        rv;
		logic [63:0]        sv;
		logic [1:0]         ri;
		logic [1:0]         si;
		logic [7:0]         off;
		logic [19:0]        raw;
		logic [3:0]         imm;
		logic               pop;
		logic               push;
		nfsd_pkg::nfsd_cond_t cond;
		m64    = 64'h0000_0000_0000_0000;
		rv     = 64'h0000_0000_0000_0000;
		sv     = 64'h0000_0000_0000_0000;
		ri     = 2'h0;
		si     = 2'h1;
		off    = paddr - nfsd_pkg::OFF_WREG;
		raw    = 20'h0_0000;
		imm    = pwdata[nfsd_pkg::IMM_LSB +: 4];
		pop    = 1'b0;
		push   = 1'b0;
		cond   = nfsd_pkg::nfsd_cond_t'(pwdata[nfsd_pkg::COND_LSB +: 3]);
		s_d    = s_q;
		op     = nfsd_pkg::nfsd_op_t'(pwdata[nfsd_pkg::OP_LSB +: 4]);
		yrtn   = pwdata[nfsd_pkg::YRTN_BIT];
		nxt_pc = s_q.pc + 20'h0_0001;
		top    = (s_q.depth != 4'h0) ? s_q.stk[s_q.sp - 3'h1] : 20'h0_0000;
		exec   = psel && penable && pwrite && (paddr == nfsd_pkg::OFF_INSTR);
		is_test = (op == nfsd_pkg::OP_TEST_REG) || (op == nfsd_pkg::OP_TEST_PTR) ||
			(op == nfsd_pkg::OP_TEST_HW) || (op == nfsd_pkg::OP_TEST_PST);
		dmask  = fs_mask(pwdata[nfsd_pkg::FS_LSB +: 4], pwdata[nfsd_pkg::AFLD_BIT],
			pwdata[nfsd_pkg::EXT_BIT], pwdata[nfsd_pkg::DCNT_LSB +: 5], s_q.ptr);
		for (int i = 0; i < 16; i++) begin
			m64[i*4 +: 4] = {4{dmask[i]}};
		end

		// Jump target: short two digits, long four, very long five absolute
		case (pwdata[nfsd_pkg::JLEN_LSB +: 2])
			2'h0: begin
				raw   = nib_rev(s_q.tgt, 2);
				tgt_v = nxt_pc + {{12{raw[7]}}, raw[7:0]};
			end
			2'h1: begin
				raw   = nib_rev(s_q.tgt, 4);
				tgt_v = nxt_pc + {{4{raw[15]}}, raw[15:0]};
			end
			default: begin
				raw   = nib_rev(s_q.tgt, 5);
				tgt_v = raw;
			end
		endcase

		// Operand pair: A-B, B-C, C-A, C-D, D-C
		case (pwdata[nfsd_pkg::PAIR_LSB +: 3])
			3'h0: begin ri = 2'h0; si = 2'h1; end
			3'h1: begin ri = 2'h1; si = 2'h2; end
			3'h2: begin ri = 2'h2; si = 2'h0; end
			3'h3: begin ri = 2'h2; si = 2'h3; end
			default: begin ri = 2'h3; si = 2'h2; end
		endcase
		// Masked operands compare as plain numbers since fields are contiguous
		rv = s_q.wreg[ri] & m64;
		sv = s_q.wreg[si] & m64;

		// Test outcome for whichever test class is decoded
		case (op)
			nfsd_pkg::OP_TEST_REG: begin
				case (cond)
					nfsd_pkg::TC_EQ:   tres = (rv == sv);
					nfsd_pkg::TC_NE:   tres = (rv != sv);
					nfsd_pkg::TC_ZERO: tres = (rv == 64'h0000_0000_0000_0000);
					nfsd_pkg::TC_NZ:   tres = (rv != 64'h0000_0000_0000_0000);
					nfsd_pkg::TC_GT:   tres = (rv > sv);
					nfsd_pkg::TC_LT:   tres = (rv < sv);
					nfsd_pkg::TC_GE:   tres = (rv >= sv);
					default:           tres = (rv <= sv);
				endcase
			end
			nfsd_pkg::OP_TEST_PTR: begin
				tres = (s_q.ptr == imm) ^ cond[0];
			end
			nfsd_pkg::OP_TEST_HW: begin
				tres = !s_q.hst[imm[1:0]];
			end
			nfsd_pkg::OP_TEST_PST: begin
				// Bit one: modes 0 and 3 true on one, 1 and 2 on zero
				tres = s_q.pst[imm] ^ (cond[1:0] == 2'h1) ^ (cond[1:0] == 2'h2);
			end
			default: begin
				tres = 1'b0;
			end
		endcase

		// Register file writes and reads; reads are latched in the setup cycle
		if (psel && penable && pwrite) begin
			if (mapped && paddr >= nfsd_pkg::OFF_WREG && paddr <= nfsd_pkg::OFF_WEND) begin
				s_d.wreg[off[4:3]][off[2]*32 +: 32] = pwdata;
			end
			case (paddr)
				nfsd_pkg::OFF_INSTR: s_d.instr = pwdata;
				nfsd_pkg::OFF_TGT:   s_d.tgt   = pwdata[19:0];
				nfsd_pkg::OFF_PTR:   s_d.ptr   = pwdata[3:0];
				nfsd_pkg::OFF_PST:   s_d.pst   = pwdata[15:0];
				nfsd_pkg::OFF_HST:   s_d.hst   = pwdata[3:0];
				nfsd_pkg::OFF_FLAGS: begin
					s_d.carry = pwdata[nfsd_pkg::FL_CARRY];
					s_d.inten = pwdata[nfsd_pkg::FL_INTEN];
				end
				nfsd_pkg::OFF_PC:    s_d.pc    = pwdata[19:0];
				default: ;
			endcase
		end
		if (psel && !penable) begin
			s_d.rdata = 32'h0000_0000;
			if (paddr >= nfsd_pkg::OFF_WREG && paddr <= nfsd_pkg::OFF_WEND) begin
				s_d.rdata = s_q.wreg[off[4:3]][off[2]*32 +: 32];
			end
			case (paddr)
				nfsd_pkg::OFF_INSTR: s_d.rdata = s_q.instr;
				nfsd_pkg::OFF_TGT:   s_d.rdata = {12'h000, s_q.tgt};
				nfsd_pkg::OFF_PTR:   s_d.rdata = {28'h000_0000, s_q.ptr};
				nfsd_pkg::OFF_PST:   s_d.rdata = {16'h0000, s_q.pst};
				nfsd_pkg::OFF_HST:   s_d.rdata = {28'h000_0000, s_q.hst};
				nfsd_pkg::OFF_FLAGS: s_d.rdata = {24'h00_0000, s_q.depth, 2'h0, s_q.inten, s_q.carry};
				nfsd_pkg::OFF_PC:    s_d.rdata = {12'h000, s_q.pc};
				default: ;
			endcase
		end

		// Execute the written instruction
		if (exec) begin
			s_d.pc = nxt_pc;
			case (op)
				nfsd_pkg::OP_JUMP: s_d.pc = tgt_v;
				nfsd_pkg::OP_BR_CARRY: begin
					if (s_q.carry) s_d.pc = tgt_v;
				end
				nfsd_pkg::OP_BR_NO_CARRY: begin
					if (!s_q.carry) s_d.pc = tgt_v;
				end
				nfsd_pkg::OP_CALL: begin
					push   = 1'b1;
					s_d.pc = tgt_v;
				end
				nfsd_pkg::OP_RETURN: pop = 1'b1;
				nfsd_pkg::OP_RET_SET_CARRY: begin
					pop       = 1'b1;
					s_d.carry = 1'b1;
				end
				nfsd_pkg::OP_RET_CLR_CARRY: begin
					pop       = 1'b1;
					s_d.carry = 1'b0;
				end
				nfsd_pkg::OP_RET_MOD_MISSING: begin
					pop = 1'b1;
					s_d.hst[nfsd_pkg::HST_MOD_MISSING] = 1'b1;
				end
				nfsd_pkg::OP_RET_INTR: begin
					pop       = 1'b1;
					s_d.inten = 1'b1;
				end
				nfsd_pkg::OP_RET_IF_CARRY:    pop = s_q.carry;
				nfsd_pkg::OP_RET_IF_NO_CARRY: pop = !s_q.carry;
				nfsd_pkg::OP_TEST_REG, nfsd_pkg::OP_TEST_PTR,
				nfsd_pkg::OP_TEST_HW, nfsd_pkg::OP_TEST_PST: begin
					s_d.carry = tres;
					// Branch or return part rides in the same word
					if (tres && yrtn) begin
						pop = 1'b1;
					end else if (tres) begin
						s_d.pc = tgt_v;
					end else begin
						s_d.pc = nxt_pc;
					end
				end
				default: ;
			endcase
			// Empty stack pops as zero, a full one drops its oldest entry
			if (pop) begin
				s_d.pc = top;
				if (s_q.depth != 4'h0) begin
					s_d.sp    = s_q.sp - 3'h1;
					s_d.depth = s_q.depth - 4'h1;
				end
			end
			if (push) begin
				s_d.stk[s_q.sp] = nxt_pc;
				s_d.sp          = s_q.sp + 3'h1;
				if (s_q.depth != 4'(nfsd_pkg::STK_DEPTH)) begin
					s_d.depth = s_q.depth + 4'h1;
				end
			end
		end
	end

	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q       <= '0;
			s_q.pc    <= nfsd_pkg::RST_PC;
			s_q.inten <= nfsd_pkg::RST_INTEN;
		end else begin
			s_q <= s_d;
		end
	end

	// Zero-wait slave; an unmapped word answers with an error
	assign mapped = (paddr[1:0] == 2'h0) && (paddr <= nfsd_pkg::OFF_PC) &&
		!(paddr > nfsd_pkg::OFF_TGT && paddr < nfsd_pkg::OFF_WREG);
	assign pready       = 1'b1;
	assign pslverr      = psel && penable && !mapped;
	assign prdata       = s_q.rdata;
	assign carry_flag   = s_q.carry;
	assign int_enable   = s_q.inten;
	assign prog_counter = s_q.pc;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// Field masks tied to the pointer, the mantissa mask and the digit count mask
	a_mask_ptr: assert property (exec && !pwdata[8] && !pwdata[9] && pwdata[6:4] == 3'h0
		|-> dmask == (16'h0001 << s_q.ptr)) else $error("pointer field mask wrong");
	a_mask_wp: assert property (exec && !pwdata[8] && !pwdata[9] && pwdata[6:4] == 3'h1
		|-> $countones(dmask) == int'(s_q.ptr) + 1 && dmask[0]) else $error("wp mask wrong");
	a_mask_mant: assert property (exec && !pwdata[8] && !pwdata[9] && pwdata[6:4] == 3'h5
		|-> dmask == 16'h7FF8) else $error("mantissa mask wrong");
	a_mask_count: assert property (exec && pwdata[9] && pwdata[14:10] <= 5'h10
		|-> $countones(dmask) == int'(pwdata[14:10])) else $error("digit count mask wrong");
	// Carry follows every test
	a_test_carry: assert property (exec && is_test |=> carry_flag == $past(tres))
		else $error("test did not set carry");
	a_test_false: assert property (exec && is_test && !tres
		|=> prog_counter == $past(nxt_pc) && s_q.depth == $past(s_q.depth) && s_q.hst == $past(s_q.hst)
		&& s_q.pst == $past(s_q.pst) && s_q.ptr == $past(s_q.ptr)) else $error("false test moved");
	a_test_rtn: assert property (exec && is_test && tres && yrtn
		|=> prog_counter == $past(top)) else $error("true test return missed");
	a_br_carry: assert property (exec && op == nfsd_pkg::OP_BR_CARRY
		|=> prog_counter == ($past(carry_flag) ? $past(tgt_v) : $past(nxt_pc))) else $error("carry branch wrong");
	a_ret_cond: assert property (exec && op == nfsd_pkg::OP_RET_IF_NO_CARRY && carry_flag
		|=> prog_counter == $past(nxt_pc)) else $error("return taken on carry");
	a_ret_flags: assert property (exec && op == nfsd_pkg::OP_RET_SET_CARRY
		|=> carry_flag && prog_counter == $past(top)) else $error("set carry return wrong");
	a_ret_intr: assert property (exec && op == nfsd_pkg::OP_RET_INTR
		|=> int_enable && prog_counter == $past(top)) else $error("interrupt return wrong");
	a_ret_missing: assert property (exec && op == nfsd_pkg::OP_RET_MOD_MISSING
		|=> s_q.hst[0] && prog_counter == $past(top)) else $error("module missing not set");
	// Two executes are never adjacent on APB, so the push is checked right after the call
	a_call_ret: assert property (exec && op == nfsd_pkg::OP_CALL
		|=> top == $past(nxt_pc) && prog_counter == $past(tgt_v)) else $error("call push mismatch");

	// Plain field-code view of the instruction for the fixed-mask checks
	logic       fs_plain;
	logic [2:0] fs_code;
	assign fs_plain = exec && !pwdata[nfsd_pkg::AFLD_BIT] && !pwdata[nfsd_pkg::EXT_BIT];
	assign fs_code  = pwdata[nfsd_pkg::FS_LSB +: 3];

	// Fixed fields, expected digits written out rather than taken from the package masks
	a_mask_esign: assert property (fs_plain && fs_code == nfsd_pkg::FS_ESGN |-> dmask == 16'h0004)
		else $error("exponent sign mask wrong");
	a_mask_exp: assert property (fs_plain && fs_code == nfsd_pkg::FS_X |-> dmask == 16'h0007)
		else $error("exponent mask wrong");
	a_mask_sign: assert property (fs_plain && fs_code == nfsd_pkg::FS_S |-> dmask == 16'h8000)
		else $error("sign mask wrong");
	a_mask_byte: assert property (fs_plain && fs_code == nfsd_pkg::FS_B |-> dmask == 16'h0003)
		else $error("byte mask wrong");
	a_mask_word: assert property (fs_plain && fs_code == nfsd_pkg::FS_W |-> dmask == 16'hFFFF)
		else $error("word mask wrong");
	a_mask_addr: assert property (exec && pwdata[nfsd_pkg::AFLD_BIT] && !pwdata[nfsd_pkg::EXT_BIT]
		|-> dmask == 16'h001F) else $error("address mask wrong");

	// Status and pointer test outcomes seen through carry
	a_test_hw: assert property (exec && op == nfsd_pkg::OP_TEST_HW
		|=> carry_flag == !$past(s_q.hst[pwdata[nfsd_pkg::IMM_LSB +: 2]])) else $error("hw status test wrong");
	a_test_ptr: assert property (exec && op == nfsd_pkg::OP_TEST_PTR && !pwdata[nfsd_pkg::COND_LSB]
		&& s_q.ptr == pwdata[nfsd_pkg::IMM_LSB +: 4] |=> carry_flag) else $error("pointer equal test wrong");
	a_test_pst: assert property (exec && op == nfsd_pkg::OP_TEST_PST && pwdata[nfsd_pkg::COND_LSB +: 2] == 2'h0
		|=> carry_flag == $past(s_q.pst[pwdata[nfsd_pkg::IMM_LSB +: 4]])) else $error("status bit test wrong");

	c_test_branch: cover property (exec && is_test && tres && !yrtn);
	c_test_return: cover property (exec && is_test && tres && yrtn);
	c_call_return: cover property (exec && op == nfsd_pkg::OP_CALL ##[1:20] exec && op == nfsd_pkg::OP_RETURN);
	c_false_test: cover property (exec && is_test && !tres);
endmodule
